// ===== dv/bridge_pwm_steer_properties.sv
`timescale 1ns/10ps
`include "bridge_pwm_consts.svh"

module bridge_pwm_steer_checker
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [`BP_ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic bridgeOutA,
    input wire logic bridgeOutB,
    input wire logic bridgeOutC,
    input wire logic bridgeOutD
);
    logic [31:0] ctrlReg;
    logic [7:0] dutyReg;
    logic [3:0] quietReg;
    // shadow decode: the outputs only make sense against mode and enable
    wire logic acc = psel && penable;
    wire logic ctrlWr = acc && pwrite && paddr == `BP_CTRL_OFFSET;
    wire logic dutyWr = acc && pwrite && paddr == `BP_DUTY_OFFSET;
    wire logic modeChg = ctrlWr && pwdata[1:0] != ctrlReg[1:0];
    wire logic settled = quietReg == 4'hf && ctrlReg[0];
    wire logic full = ctrlReg[1];

    // quiet counter restarts on mode or enable change only, not on direction
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            ctrlReg <= 32'h0;
            dutyReg <= 8'h00;
            quietReg <= 4'h0;
        end
        else
        begin
            ctrlReg <= ctrlWr ? pwdata : ctrlReg;
            dutyReg <= dutyWr ? pwdata[7:0] : dutyReg;
            quietReg <= modeChg ? 4'h0 : (quietReg == 4'hf ? quietReg : quietReg + 4'h1);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_mod_quiet;
        !bridgeOutB && !bridgeOutD;
    endsequence

    property p_ready;
        acc |-> pready;
    endproperty
    a_ready: assert property (p_ready) else $error("pready low in access phase");
    property p_err_idle;
        !acc |-> !pslverr;
    endproperty
    a_err_idle: assert property (p_err_idle) else $error("pslverr outside access");
    property p_half_pair;
        settled && !full |-> !bridgeOutC && !bridgeOutD;
    endproperty
    a_half_pair: assert property (p_half_pair) else $error("half mode drives c or d");
    property p_half_gap;
        settled && !full |-> !(bridgeOutA && bridgeOutB);
    endproperty
    a_half_gap: assert property (p_half_gap) else $error("half pair overlap");
    property p_one_mod;
        settled && full |-> !(bridgeOutB && bridgeOutD) && (bridgeOutA ^ bridgeOutC);
    endproperty
    a_one_mod: assert property (p_one_mod) else $error("full mode drive set");
    property p_dir_set;
        settled && full |-> (bridgeOutA |-> !bridgeOutB) and (bridgeOutC |-> !bridgeOutD);
    endproperty
    a_dir_set: assert property (p_dir_set) else $error("wrong leg modulated");
    property p_swap_rev;
        settled && full && $fell(bridgeOutA) |-> bridgeOutC ##0 s_mod_quiet;
    endproperty
    a_swap_rev: assert property (p_swap_rev) else $error("reverse swap bad");
    property p_swap_fwd;
        settled && full && $fell(bridgeOutC) |-> bridgeOutA ##0 s_mod_quiet;
    endproperty
    a_swap_fwd: assert property (p_swap_fwd) else $error("forward swap bad");
    property p_restart;
        settled && full && $rose(bridgeOutC) && dutyReg != 8'h00 && ctrlReg[5:4] == 2'h0
            |-> !bridgeOutB ##[1:3] bridgeOutB;
    endproperty
    a_restart: assert property (p_restart) else $error("no restart after blank");
    property p_hold_dir;
        settled && full && ctrlWr && pwdata[2] != ctrlReg[2]
            |=> $stable(bridgeOutA) && $stable(bridgeOutC);
    endproperty
    a_hold_dir: assert property (p_hold_dir) else $error("direction taken early");
endmodule // bridge_pwm_steer_checker

bind bridge_pwm_steer bridge_pwm_steer_checker chk (.clk, .reset, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .bridgeOutA, .bridgeOutB, .bridgeOutC,
    .bridgeOutD);

// ===== dv/bridge_switch_model.sv
`timescale 1ns/10ps

module bridge_switch_model
(
    input wire logic clk,
    input wire logic reset,
    input wire logic gateA, // pins taken as driven outputs
    input wire logic gateB,
    input wire logic gateC,
    input wire logic gateD,
    output int shootCount
);
    // legs are a over b and c over d; both on shorts the supply
    always_ff @(posedge clk)
    begin
        if (reset)
            shootCount <= 0;
        else if ((gateA && gateB) || (gateC && gateD))
            shootCount <= shootCount + 1;
    end
endmodule // bridge_switch_model

// ===== dv/test_bridge_pwm_steer.sv
`timescale 1ns/10ps
`include "bridge_pwm_consts.svh"

module test_bridge_pwm_steer;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [`BP_ADDR_W-1:0] paddr = '0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, outA, outB, outC, outD;
    logic [31:0] rd;
    logic err;
    int shootCount, nErrors, checksDone, w, per, duty, db, pre;
    int cnt [4];
    int seed = 32'hab097528;

    bridge_pwm_steer #(.TIMER_W(8), .DB_W(7)) dut (.clk(clk), .reset(reset), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .bridgeOutA(outA), .bridgeOutB(outB),
        .bridgeOutC(outC), .bridgeOutD(outD));
    bridge_switch_model sw (.clk(clk), .reset(reset), .gateA(outA), .gateB(outB),
        .gateC(outC), .gateD(outD), .shootCount(shootCount));

    always #2 clk = ~clk;

    task automatic finishTest();
        $display("checks %0d mismatches %0d", checksDone, nErrors);
        if (nErrors == 0 && checksDone > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp)
        begin
            nErrors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one apb transfer, idle cycle after so strobes never toggle twice at one edge
    task automatic apb(input logic wr, input logic [`BP_ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        @(posedge clk);
        while (pready !== 1'b1)
        begin
            @(posedge clk);
            n++;
        end
        chk(32'(n), 32'h0);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    // high clocks per period; dead-band trims only the rising side
    function automatic int hiLen(int p, int dt, int dv, int dbv, bit comp);
        int fl, on;
        fl = (p + 1) * dv;
        on = ((dt > p) ? p + 1 : dt) * dv;
        if (comp)
            on = fl - on;
        if (on == 0 || on == fl)
            return on;
        return (on > dbv) ? on - dbv : 0;
    endfunction

    task automatic waitOut(input int idx);
        w = 0;
        while ((idx == 0 ? outA : idx == 1 ? outB : idx == 2 ? outC : outD) !== 1'b1
            && w < 5000)
        begin
            @(posedge clk);
            w++;
        end
        chk(32'(w < 5000), 32'h1);
    endtask

    task automatic runCase(int p, int dt, int dbv, int ps, bit fullMode);
        int dv, n;
        dv = (ps == 0) ? 1 : (ps == 1) ? 4 : 16;
        n = 2 * (p + 1) * dv;
        apb(1, `BP_CTRL_OFFSET, 32'h0);
        apb(1, `BP_PERIOD_OFFSET, 32'(p));
        apb(1, `BP_DUTY_OFFSET, 32'(dt));
        apb(1, `BP_DEADBAND_OFFSET, 32'(dbv));
        apb(1, `BP_CTRL_OFFSET, {26'h0, 2'(ps), 2'b00, fullMode, 1'b1});
        repeat (n + 8) @(posedge clk);
        cnt = '{0, 0, 0, 0};
        repeat (n)
        begin
            @(posedge clk);
            cnt[0] += outA;
            cnt[1] += outB;
            cnt[2] += outC;
            cnt[3] += outD;
        end
        if (fullMode)
        begin
            chk(32'(cnt[0]), 32'(n));
            chk(32'(cnt[3]), 32'(2 * hiLen(p, dt, dv, 0, 0)));
            chk(32'(cnt[1] + cnt[2]), 32'h0);
        end
        else
        begin
            chk(32'(cnt[0]), 32'(2 * hiLen(p, dt, dv, dbv, 0)));
            chk(32'(cnt[1]), 32'(2 * hiLen(p, dt, dv, dbv, 1)));
            chk(32'(cnt[2] + cnt[3]), 32'h0);
        end
        $display("case per %0d duty %0d db %0d pre %0d full %0d done", p, dt, dbv, ps, fullMode);
    endtask

    // hang guard, about the whole planned run plus margin
    initial
    begin
        #200000;
        nErrors++;
        $display("watchdog expired");
        finishTest();
    end

    initial
    begin
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        apb(0, `BP_PERIOD_OFFSET, 32'h0);
        chk(rd, 32'hff);
        apb(1, `BP_DEADBAND_OFFSET, 32'hffffffff);
        apb(0, `BP_DEADBAND_OFFSET, 32'h0);
        chk(rd, 32'h7f);
        apb(1, 12'h020, 32'h5);
        chk({31'h0, err}, 32'h1);
        apb(0, 12'h020, 32'h0);
        chk(rd, 32'h0);
        $display("register test done");
        runCase(40, 5, 100, 0, 0);
        runCase(20, 0, 3, 1, 0);
        runCase(20, 21, 3, 0, 0);
        for (int i = 0; i < 6; i++)
        begin
            per = 8 + ($unsigned($random(seed)) % 56);
            duty = $unsigned($random(seed)) % (per + 2);
            db = $unsigned($random(seed)) % 32;
            pre = $unsigned($random(seed)) % 4;
            runCase(per, duty, db, pre, 0);
        end
        runCase(40, 30, 60, 0, 1);
        apb(1, `BP_DUTY_OFFSET, 32'h8); // lower duty a period before reversal
        @(negedge outD);
        waitOut(3);
        apb(1, `BP_CTRL_OFFSET, 32'h7);
        apb(0, `BP_STATUS_OFFSET, 32'h0);
        chk({30'h0, rd[`BP_STAT_STATE_MSB:`BP_STAT_STATE_LSB]}, 32'h1);
        chk({31'h0, rd[`BP_STAT_STATDIR_BIT]}, 32'h0);
        chk({31'h0, rd[`BP_STAT_MODDIR_BIT]}, 32'h0);
        waitOut(2);
        chk({29'h0, outA, outB, outD}, 32'h0);
        apb(1, `BP_DUTY_OFFSET, 32'd30);
        waitOut(1);
        chk({31'h0, outC}, 32'h1);
        apb(1, `BP_CTRL_OFFSET, 32'h3);
        waitOut(0);
        chk({29'h0, outB, outC, outD}, 32'h0);
        $display("direction test done");
        chk(32'(shootCount), 32'h0);
        finishTest();
    end
endmodule // test_bridge_pwm_steer

// ===== src/bridge_pwm_consts.svh
`ifndef BRIDGE_PWM_CONSTS_SVH
`define BRIDGE_PWM_CONSTS_SVH

// register byte offsets on the apb bus
`define BP_ADDR_W 12
`define BP_CTRL_OFFSET 12'h000
`define BP_DEADBAND_OFFSET 12'h004
`define BP_PERIOD_OFFSET 12'h008
`define BP_DUTY_OFFSET 12'h00c
`define BP_STATUS_OFFSET 12'h010

// control register fields
`define BP_CTRL_EN_BIT 0
`define BP_CTRL_MODE_BIT 1
`define BP_CTRL_DIR_BIT 2
`define BP_CTRL_PRE_LSB 4
`define BP_CTRL_PRE_MSB 5

// status register fields
`define BP_STAT_MODDIR_BIT 0
`define BP_STAT_STATDIR_BIT 1
`define BP_STAT_STATE_LSB 2
`define BP_STAT_STATE_MSB 3
`define BP_STAT_TIMER_LSB 8
`define BP_STAT_TIMER_MSB 15
`define BP_STAT_OUT_LSB 16
`define BP_STAT_OUT_MSB 19

// reset values
`define BP_PRE_RESET 2'h0
`define BP_DEADBAND_RESET 7'h00
`define BP_PERIOD_RESET 8'hff
`define BP_DUTY_RESET 8'h00

// prescale terminal counts: divide by 1, 4 and 16 clocks
`define BP_PRE_DIV1_LAST 4'h0
`define BP_PRE_DIV4_LAST 4'h3
`define BP_PRE_DIV16_LAST 4'hf

`endif

// ===== src/bridge_pwm_pkg.sv
package bridge_pwm_pkg;

    typedef enum logic
    {
        MODE_HALF = 1'b0,
        MODE_FULL = 1'b1
    } bridge_mode_e;

    typedef enum logic
    {
        DIR_FWD = 1'b0,
        DIR_REV = 1'b1
    } direction_e;

    typedef enum logic [1:0]
    {
        ST_RUN = 2'b00,
        ST_PEND = 2'b01,
        ST_BLANK = 2'b10
    } steer_state_e;

endpackage

// ===== src/bridge_pwm_steer.sv
`timescale 1ns/10ps
`include "bridge_pwm_consts.svh"

//Behaviour
// - half-bridge: output A carries the pwm, output B its complement
// - half-bridge: 7-bit dead-band delays each output's activation by that many cycles
// - dead-band at or above an output's high time in clocks, if that time is under a full period, keeps that delayed output inactive all period
// - full-bridge: one direction bit selects forward or reverse drive
// - a new direction takes effect from the next pwm period
// - pending change forces both modulated outputs inactive before period ends
// - pending change swaps the two static outputs before period ends
// - modulation restarts on the new modulated output at next period start
// - full-bridge applies no dead-band delay at all
// - full-bridge: one output modulated, the other direction output held on
// - forward to reverse: A and D drop as C rises, same cycle
// - direction may be written any time without corrupting the period
// - blanking lasts one period-timer count, prescale clocks long
module bridge_pwm_steer #(
    parameter int TIMER_W = 8,
    parameter int DB_W = 7
)
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [`BP_ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic bridgeOutA,
    output logic bridgeOutB,
    output logic bridgeOutC,
    output logic bridgeOutD
);
    // software-visible configuration
    logic enable_reg;
    bridge_pwm_pkg::bridge_mode_e mode_reg;
    bridge_pwm_pkg::direction_e dirReq_reg;
    logic [1:0] prescale_reg;
    logic [DB_W-1:0] deadband_reg;
    logic [TIMER_W-1:0] period_reg;
    logic [TIMER_W-1:0] duty_reg;

    // timebase
    logic [3:0] preCnt_reg;
    logic [3:0] preCnt_next;
    logic [TIMER_W-1:0] timer_reg;
    logic [TIMER_W-1:0] timer_next;

    // steering state
    bridge_pwm_pkg::steer_state_e state_reg;
    bridge_pwm_pkg::steer_state_e state_next;
    bridge_pwm_pkg::direction_e staticDir_reg;
    bridge_pwm_pkg::direction_e staticDir_next;
    bridge_pwm_pkg::direction_e modDir_reg;
    bridge_pwm_pkg::direction_e modDir_next;

    // pins and bus read data
    logic outA_reg;
    logic outB_reg;
    logic outC_reg;
    logic outD_reg;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;

    deadband_if #(.CW(DB_W)) dbA ();
    deadband_if #(.CW(DB_W)) dbB ();

    // terminal prescale count for a field value
    function automatic logic [3:0] prescaleLast(input logic [1:0] sel);
        case (sel)
            2'h0: prescaleLast = `BP_PRE_DIV1_LAST;
            2'h1: prescaleLast = `BP_PRE_DIV4_LAST;
            default: prescaleLast = `BP_PRE_DIV16_LAST;
        endcase
    endfunction

    // apb decode; the slave never inserts wait states
    wire logic setupPhase;
    wire logic accessPhase;
    wire logic hitCtrl;
    wire logic hitDeadband;
    wire logic hitPeriod;
    wire logic hitDuty;
    wire logic hitStatus;
    wire logic hitAny;
    wire logic writeStrobe;

    assign setupPhase = psel & ~penable;
    assign accessPhase = psel & penable;
    assign hitCtrl = (paddr == `BP_CTRL_OFFSET);
    assign hitDeadband = (paddr == `BP_DEADBAND_OFFSET);
    assign hitPeriod = (paddr == `BP_PERIOD_OFFSET);
    assign hitDuty = (paddr == `BP_DUTY_OFFSET);
    assign hitStatus = (paddr == `BP_STATUS_OFFSET);
    assign hitAny = hitCtrl | hitDeadband | hitPeriod | hitDuty | hitStatus;
    assign writeStrobe = accessPhase & pwrite & hitAny;
    assign pready = 1'b1;
    assign pslverr = accessPhase & ~hitAny;

    // prescaled period timer; the last count of a period is the blanking slot
    wire logic tick;
    wire logic lastCount;
    wire logic periodEnd;
    wire logic rawPwm;
    wire logic halfMode;
    wire logic fullMode;

    assign tick = (preCnt_reg == prescaleLast(prescale_reg));
    assign lastCount = (timer_reg == period_reg);
    assign periodEnd = tick & lastCount;
    assign rawPwm = enable_reg & (timer_reg < duty_reg);
    assign halfMode = enable_reg & (mode_reg == bridge_pwm_pkg::MODE_HALF);
    assign fullMode = enable_reg & (mode_reg == bridge_pwm_pkg::MODE_FULL);
    assign preCnt_next = (!enable_reg || tick) ? 4'h0 : preCnt_reg + 4'h1;
    assign timer_next = !enable_reg ? '0
                      : !tick ? timer_reg
                      : lastCount ? '0 : timer_reg + TIMER_W'(1);

    // direction change sequencer
    always_comb
    begin
        state_next = state_reg;
        staticDir_next = staticDir_reg;
        modDir_next = modDir_reg;
        if (!fullMode)
        begin
            // outside full-bridge the direction simply follows software
            state_next = bridge_pwm_pkg::ST_RUN;
            staticDir_next = dirReq_reg;
            modDir_next = dirReq_reg;
        end
        else
        begin
            case (state_reg)
                bridge_pwm_pkg::ST_RUN:
                begin
                    // a write only arms the change, the period runs on
                    if (dirReq_reg != modDir_reg)
                    begin
                        state_next = bridge_pwm_pkg::ST_PEND;
                    end
                end
                bridge_pwm_pkg::ST_PEND:
                begin
                    if (dirReq_reg == modDir_reg)
                    begin
                        state_next = bridge_pwm_pkg::ST_RUN; // written back, nothing to do
                    end
                    else if (timer_next == period_reg)
                    begin
                        // enter with the last count so blanking spans all of it
                        state_next = bridge_pwm_pkg::ST_BLANK;
                        staticDir_next = dirReq_reg;
                    end
                end
                bridge_pwm_pkg::ST_BLANK:
                begin
                    if (periodEnd)
                    begin
                        // new modulated output starts with the next period
                        state_next = bridge_pwm_pkg::ST_RUN;
                        modDir_next = staticDir_reg;
                    end
                end
                default:
                begin
                    state_next = bridge_pwm_pkg::ST_RUN;
                end
            endcase
        end
    end

    // dead-band units only delay in half-bridge mode
    assign dbA.request = halfMode & rawPwm;
    assign dbA.enable = halfMode;
    assign dbA.countVal = deadband_reg;
    assign dbB.request = halfMode & ~rawPwm; // complement
    assign dbB.enable = halfMode;
    assign dbB.countVal = deadband_reg;

    deadband_delay #(.CW(DB_W)) deadbandA
    (
        .clk(clk),
        .reset(reset),
        .db(dbA)
    );

    deadband_delay #(.CW(DB_W)) deadbandB
    (
        .clk(clk),
        .reset(reset),
        .db(dbB)
    );

    // full-bridge output selection
    wire logic blanking;
    wire logic fwdStatic;
    wire logic revStatic;
    wire logic fwdMod;
    wire logic revMod;
    wire logic outA_next;
    wire logic outB_next;
    wire logic outC_next;
    wire logic outD_next;

    assign blanking = (state_reg == bridge_pwm_pkg::ST_BLANK);
    assign fwdStatic = fullMode & (staticDir_reg == bridge_pwm_pkg::DIR_FWD);
    assign revStatic = fullMode & (staticDir_reg == bridge_pwm_pkg::DIR_REV);
    assign fwdMod = fullMode & (modDir_reg == bridge_pwm_pkg::DIR_FWD) & ~blanking;
    assign revMod = fullMode & (modDir_reg == bridge_pwm_pkg::DIR_REV) & ~blanking;

    // static and modulated outputs switch on the same edge
    assign outA_next = halfMode ? dbA.delayed : fwdStatic;
    assign outB_next = halfMode ? dbB.delayed : (revMod & rawPwm);
    assign outC_next = revStatic;
    assign outD_next = fwdMod & rawPwm;

    // read data is latched in the setup phase so it is stable in access
    always_comb
    begin
        prdata_next = 32'h0000_0000;
        if (hitCtrl)
        begin
            prdata_next[`BP_CTRL_EN_BIT] = enable_reg;
            prdata_next[`BP_CTRL_MODE_BIT] = mode_reg;
            prdata_next[`BP_CTRL_DIR_BIT] = dirReq_reg;
            prdata_next[`BP_CTRL_PRE_MSB:`BP_CTRL_PRE_LSB] = prescale_reg;
        end
        else if (hitDeadband)
        begin
            prdata_next[DB_W-1:0] = deadband_reg;
        end
        else if (hitPeriod)
        begin
            prdata_next[TIMER_W-1:0] = period_reg;
        end
        else if (hitDuty)
        begin
            prdata_next[TIMER_W-1:0] = duty_reg;
        end
        else if (hitStatus)
        begin
            prdata_next[`BP_STAT_MODDIR_BIT] = modDir_reg;
            prdata_next[`BP_STAT_STATDIR_BIT] = staticDir_reg;
            prdata_next[`BP_STAT_STATE_MSB:`BP_STAT_STATE_LSB] = state_reg;
            prdata_next[`BP_STAT_TIMER_MSB:`BP_STAT_TIMER_LSB] = 8'(timer_reg);
            prdata_next[`BP_STAT_OUT_MSB:`BP_STAT_OUT_LSB] =
                {outD_reg, outC_reg, outB_reg, outA_reg};
        end
    end

    // software registers; a write lands at the access edge only
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            enable_reg <= 1'b0;
            mode_reg <= bridge_pwm_pkg::MODE_HALF;
            dirReq_reg <= bridge_pwm_pkg::DIR_FWD;
            prescale_reg <= `BP_PRE_RESET;
        end
        else if (writeStrobe && hitCtrl)
        begin
            enable_reg <= pwdata[`BP_CTRL_EN_BIT];
            mode_reg <= bridge_pwm_pkg::bridge_mode_e'(pwdata[`BP_CTRL_MODE_BIT]);
            dirReq_reg <= bridge_pwm_pkg::direction_e'(pwdata[`BP_CTRL_DIR_BIT]);
            prescale_reg <= pwdata[`BP_CTRL_PRE_MSB:`BP_CTRL_PRE_LSB];
        end
    end

    // period figures, written at any time, used from the next compare
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            deadband_reg <= `BP_DEADBAND_RESET;
            period_reg <= `BP_PERIOD_RESET;
            duty_reg <= `BP_DUTY_RESET;
        end
        else if (writeStrobe)
        begin
            if (hitDeadband)
            begin
                deadband_reg <= pwdata[DB_W-1:0];
            end
            if (hitPeriod)
            begin
                period_reg <= pwdata[TIMER_W-1:0];
            end
            if (hitDuty)
            begin
                duty_reg <= pwdata[TIMER_W-1:0];
            end
        end
    end

    // timebase and steering state
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            preCnt_reg <= 4'h0;
            timer_reg <= '0;
            state_reg <= bridge_pwm_pkg::ST_RUN;
            staticDir_reg <= bridge_pwm_pkg::DIR_FWD;
            modDir_reg <= bridge_pwm_pkg::DIR_FWD;
        end
        else
        begin
            preCnt_reg <= preCnt_next;
            timer_reg <= timer_next;
            state_reg <= state_next;
            staticDir_reg <= staticDir_next;
            modDir_reg <= modDir_next;
        end
    end

    // output pins and read data registered, glitch free toward the drivers
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            outA_reg <= 1'b0;
            outB_reg <= 1'b0;
            outC_reg <= 1'b0;
            outD_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end
        else
        begin
            outA_reg <= outA_next;
            outB_reg <= outB_next;
            outC_reg <= outC_next;
            outD_reg <= outD_next;
            if (setupPhase)
            begin
                prdata_reg <= prdata_next;
            end
        end
    end

    assign prdata = prdata_reg;
    assign bridgeOutA = outA_reg;
    assign bridgeOutB = outB_reg;
    assign bridgeOutC = outC_reg;
    assign bridgeOutD = outD_reg;
endmodule // bridge_pwm_steer

// ===== src/deadband_delay.sv
`timescale 1ns/10ps

module deadband_delay #(parameter int CW = 7)
(
    input wire logic clk,
    input wire logic reset,
    deadband_if.unit db
);
    logic reqPrev_reg;
    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    logic out_reg;
    logic out_next;
    wire logic rise;
    wire logic expiring;

    // the counter reloads on every active-edge request
    assign rise = db.request & ~reqPrev_reg;
    assign expiring = (cnt_reg == CW'(1));
    assign cnt_next = rise ? db.countVal
                    : (cnt_reg != '0) ? cnt_reg - CW'(1) : cnt_reg;

    // falling request drops at once; only the rising edge is delayed
    assign out_next = !db.request ? 1'b0
                    : !db.enable ? 1'b1 // no delay when bypassed
                    : rise ? (db.countVal == '0)
                    : (out_reg | expiring); // asserts only if still requested

    // one register stage whether delayed or not keeps both paths aligned
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            reqPrev_reg <= 1'b0;
            cnt_reg <= '0;
            out_reg <= 1'b0;
        end
        else
        begin
            reqPrev_reg <= db.request;
            cnt_reg <= cnt_next;
            out_reg <= out_next;
        end
    end

    assign db.delayed = out_reg;
endmodule // deadband_delay

// ===== src/deadband_if.sv
`timescale 1ns/10ps

interface deadband_if #(parameter int CW = 7);
    logic request;
    logic enable;
    logic [CW-1:0] countVal;
    logic delayed;

    modport source
    (
        output request,
        output enable,
        output countVal,
        input delayed
    );

    modport unit
    (
        input request,
        input enable,
        input countVal,
        output delayed
    );
endinterface
